//--- shared/alert_mask_pkg.sv
// Shared constants for the alert mask bank and its serial link
package alert_mask_pkg;

  // Shared command code and selector bytes
  localparam logic [7:0] MASK_CMD = 8'h1b;
  localparam logic [7:0] SEL_INPUT = 8'h7c;
  localparam logic [7:0] SEL_TEMP = 8'h7d;
  localparam logic [7:0] SEL_CML = 8'h7e;
  localparam logic [7:0] SEL_OTHER = 8'h7f;
  localparam logic [7:0] SEL_VENDOR = 8'h80;

  localparam int NUM_MASKS = 5;
  localparam logic [2:0] IDX_INPUT = 3'h0;
  localparam logic [2:0] IDX_TEMP = 3'h1;
  localparam logic [2:0] IDX_CML = 3'h2;
  localparam logic [2:0] IDX_OTHER = 3'h3;
  localparam logic [2:0] IDX_VENDOR = 3'h4;

  // Per entry, index 0 rightmost: input, temp, comm/logic, misc, vendor.
  // input: 7 overvoltage fault, 6 overvoltage warning, 5 undervoltage warning, 3 too low
  // temp: 7 overtemp fault, 6 overtemp warning
  // comm/logic: 7 invalid cmd, 6 invalid data, 5 packet check, 4 memory, 3 processor, 1 other
  // misc: 0 first alert source, fixed at one
  localparam logic [NUM_MASKS-1:0][7:0] WRITABLE = {8'h00, 8'h00, 8'hfa, 8'hc0, 8'he8};
  localparam logic [NUM_MASKS-1:0][7:0] NVM_RESET_BITS = {8'h00, 8'h00, 8'hfa, 8'hc0, 8'h08};
  localparam logic [NUM_MASKS-1:0][7:0] FIXED_ONES = {8'h00, 8'h01, 8'h00, 8'h00, 8'h00};

  localparam logic [7:0] ALL_PHASES = 8'hff;
  localparam logic [7:0] BLOCK_COUNT = 8'h01;
  localparam logic [7:0] NO_DATA = 8'h00;
  localparam logic [7:0] FILL_BYTE = 8'hff;
  // Bytes seen after start in a write word: address, command, low, high
  localparam logic [3:0] WORD_FRAME_LEN = 4'h4;
  // Arbitrary bus address, no meaning beyond the bench
  localparam logic [6:0] DEFAULT_DEV_ADDR = 7'h2a;

  localparam int CLK_PERIOD_NS = 50;
  localparam int SCL_QUARTER_NS = 150;
  localparam int SCL_QUARTER_CYC = (SCL_QUARTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

endpackage

//--- shared/alert_link_if.sv
// Open-drain serial link and alert line between host and mask bank
interface alert_link_if;
  logic scl_host_out;
  logic scl_host_oe;
  logic sda_host_out;
  logic sda_host_oe;
  logic sda_dev_out;
  logic sda_dev_oe;
  logic alert_dev_out;
  logic alert_dev_oe;
  logic scl;
  logic sda;
  logic alert_n;

  // Wired-and with pull-ups
  assign scl = ~(scl_host_oe & ~scl_host_out);
  assign sda = ~(sda_host_oe & ~sda_host_out) & ~(sda_dev_oe & ~sda_dev_out);
  assign alert_n = ~(alert_dev_oe & ~alert_dev_out);

  modport device(input scl, input sda, output sda_dev_out, output sda_dev_oe,
    output alert_dev_out, output alert_dev_oe);
  modport host(input sda, input alert_n, output scl_host_out, output scl_host_oe,
    output sda_host_out, output sda_host_oe);
endinterface

//--- hw/alert_source_mask_bank.sv
// Device end: alert mask bank with its serial slave and alert driver
// Notes on behaviour
// - Shared command; 7Dh temperature, 7Eh comm/logic
// - Selector 7Fh misc, 80h vendor mask
// - Selector 7Ch addresses the input mask
// - Masks written by write word transaction
// - Word low byte selector, high byte mask
// - Masks read by block process call
// - One-byte selector block in, one-byte mask out
// - Mask zero passes alert, one blocks it
// - Masking never blocks the status bit itself
// - Input mask bits 7,6,5,3; others zero
// - Input 7:5 reset zero, bit 3 nonvolatile
// - Comm/logic bits 7:3,1 nonvolatile; 2,0 zero
// - Misc bit 0 fixed one, 7:1 zero
// - Masks applied only with all-phases value
// - Nonvolatile backup; writes act at once
module alert_source_mask_bank #(
  parameter logic [6:0] DEV_ADDR = alert_mask_pkg::DEFAULT_DEV_ADDR
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic ce,
  alert_link_if.device link,
  input wire logic [7:0] phase_value,
  input wire logic [alert_mask_pkg::NUM_MASKS-1:0][7:0] nvm_mask,
  input wire logic [alert_mask_pkg::NUM_MASKS-1:0][7:0] status_bits,
  output logic nvm_save,
  output logic [2:0] nvm_save_idx,
  output logic [7:0] nvm_save_data,
  output logic [alert_mask_pkg::NUM_MASKS-1:0][7:0] mask_value,
  output logic alert_active
);

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_RX = 3'b010,
    ST_TX = 3'b100
  } slave_state_t;

  ////////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers and bus events

  logic scl_s1_reg, scl_s2_reg, scl_d_reg;
  logic sda_s1_reg, sda_s2_reg, sda_d_reg;

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      scl_s1_reg <= 1'b1;
      scl_s2_reg <= 1'b1;
      scl_d_reg <= 1'b1;
      sda_s1_reg <= 1'b1;
      sda_s2_reg <= 1'b1;
      sda_d_reg <= 1'b1;
    end else if (ce) begin
      scl_s1_reg <= link.scl;
      scl_s2_reg <= scl_s1_reg;
      scl_d_reg <= scl_s2_reg;
      sda_s1_reg <= link.sda;
      sda_s2_reg <= sda_s1_reg;
      sda_d_reg <= sda_s2_reg;
    end
  end

  wire scl_rise = scl_s2_reg & ~scl_d_reg;
  wire scl_fall = ~scl_s2_reg & scl_d_reg;
  wire bus_start = scl_s2_reg & scl_d_reg & sda_d_reg & ~sda_s2_reg;
  wire bus_stop = scl_s2_reg & scl_d_reg & ~sda_d_reg & sda_s2_reg;

  ////////////////////////////////////////////////////////////////////////////////
  // Slave state

  slave_state_t state_reg, state_next;
  logic [3:0] bit_cnt_reg, bit_cnt_next;
  logic [7:0] shift_reg, shift_next;
  logic [3:0] byte_idx_reg, byte_idx_next;
  logic [3:0] wr_len_reg, wr_len_next;
  logic [7:0] cmd_reg, cmd_next;
  logic [7:0] lo_reg, lo_next;
  logic [7:0] hi_reg, hi_next;
  logic rd_reg, rd_next;
  logic [7:0] tx_reg, tx_next;
  logic [1:0] tx_idx_reg, tx_idx_next;
  logic mack_reg, mack_next;
  logic sda_low_reg, sda_low_next;
  logic alert_reg;

  // Selector decode: a valid flag over a mask index
  function automatic logic [3:0] decode_sel(input logic [7:0] sel);
    case (sel)
      alert_mask_pkg::SEL_INPUT: decode_sel = {1'b1, alert_mask_pkg::IDX_INPUT};
      alert_mask_pkg::SEL_TEMP: decode_sel = {1'b1, alert_mask_pkg::IDX_TEMP};
      alert_mask_pkg::SEL_CML: decode_sel = {1'b1, alert_mask_pkg::IDX_CML};
      alert_mask_pkg::SEL_OTHER: decode_sel = {1'b1, alert_mask_pkg::IDX_OTHER};
      alert_mask_pkg::SEL_VENDOR: decode_sel = {1'b1, alert_mask_pkg::IDX_VENDOR};
      default: decode_sel = 4'h0;
    endcase
  endfunction

  wire [3:0] wr_dec = decode_sel(lo_reg);
  wire [3:0] rd_dec = decode_sel(hi_reg);
  wire cmd_ok = (cmd_reg == alert_mask_pkg::MASK_CMD);
  wire phase_ok = (phase_value == alert_mask_pkg::ALL_PHASES);

  // Write word is committed at its stop, only when exactly four bytes arrived
  wire commit = bus_stop && state_reg == ST_RX && !rd_reg && cmd_ok && wr_dec[3] && phase_ok
    && byte_idx_reg == alert_mask_pkg::WORD_FRAME_LEN;
  // Process call: command, count of one, selector, then repeated start
  wire rd_ok = wr_len_reg == alert_mask_pkg::WORD_FRAME_LEN && cmd_ok
    && lo_reg == alert_mask_pkg::BLOCK_COUNT && rd_dec[3];
  wire [7:0] rd_mask = rd_ok ? mask_value[rd_dec[2:0]] : alert_mask_pkg::NO_DATA;
  wire [7:0] tx_data = (tx_idx_reg == 2'h0) ? alert_mask_pkg::BLOCK_COUNT :
    (tx_idx_reg == 2'h1) ? rd_mask : alert_mask_pkg::FILL_BYTE;

  always_comb begin
    state_next = state_reg;
    bit_cnt_next = bit_cnt_reg;
    shift_next = shift_reg;
    byte_idx_next = byte_idx_reg;
    wr_len_next = wr_len_reg;
    cmd_next = cmd_reg;
    lo_next = lo_reg;
    hi_next = hi_reg;
    rd_next = rd_reg;
    tx_next = tx_reg;
    tx_idx_next = tx_idx_reg;
    mack_next = mack_reg;
    sda_low_next = sda_low_reg;
    if (bus_start) begin
      // A repeated start keeps the length of the write phase for the read
      wr_len_next = (state_reg == ST_IDLE) ? 4'h0 : byte_idx_reg;
      state_next = ST_RX;
      bit_cnt_next = 4'h0;
      byte_idx_next = 4'h0;
      rd_next = 1'b0;
      tx_idx_next = 2'h0;
      sda_low_next = 1'b0;
    end else if (bus_stop) begin
      state_next = ST_IDLE;
      sda_low_next = 1'b0;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          sda_low_next = 1'b0;
        end
        ST_RX: begin
          if (scl_rise && bit_cnt_reg != 4'h9) begin
            if (bit_cnt_reg < 4'h8) begin
              shift_next = {shift_reg[6:0], sda_s2_reg};
            end
            bit_cnt_next = bit_cnt_reg + 4'h1;
          end
          if (scl_fall && bit_cnt_reg == 4'h8) begin
            if (byte_idx_reg == 4'h0) begin
              if (shift_reg[7:1] == DEV_ADDR) begin
                sda_low_next = 1'b1;
                rd_next = shift_reg[0];
                byte_idx_next = 4'h1;
              end else begin
                state_next = ST_IDLE;
              end
            end else begin
              sda_low_next = 1'b1;
              case (byte_idx_reg)
                4'h1: cmd_next = shift_reg;
                4'h2: lo_next = shift_reg;
                4'h3: hi_next = shift_reg;
                default: ;
              endcase
              if (byte_idx_reg != 4'hf) begin
                byte_idx_next = byte_idx_reg + 4'h1;
              end
            end
          end else if (scl_fall && bit_cnt_reg == 4'h9) begin
            sda_low_next = 1'b0;
            bit_cnt_next = 4'h0;
            if (rd_reg) begin
              state_next = ST_TX;
              tx_next = tx_data;
              tx_idx_next = 2'h1;
              sda_low_next = ~tx_data[7];
            end
          end
        end
        ST_TX: begin
          if (scl_rise && bit_cnt_reg < 4'h9) begin
            if (bit_cnt_reg == 4'h8) begin
              mack_next = ~sda_s2_reg;
            end
            bit_cnt_next = bit_cnt_reg + 4'h1;
          end
          if (scl_fall) begin
            if (bit_cnt_reg < 4'h8) begin
              tx_next = {tx_reg[6:0], 1'b0};
              sda_low_next = ~tx_reg[6];
            end else if (bit_cnt_reg == 4'h8) begin
              sda_low_next = 1'b0;
            end else if (mack_reg) begin
              tx_next = tx_data;
              sda_low_next = ~tx_data[7];
              bit_cnt_next = 4'h0;
              if (tx_idx_reg != 2'h3) begin
                tx_idx_next = tx_idx_reg + 2'h1;
              end
            end else begin
              // Host ended the read with a not-acknowledge
              state_next = ST_IDLE;
              sda_low_next = 1'b0;
            end
          end
        end
        default: begin
          state_next = ST_IDLE;
          sda_low_next = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      state_reg <= ST_IDLE;
      bit_cnt_reg <= 4'h0;
      shift_reg <= 8'h00;
      byte_idx_reg <= 4'h0;
      wr_len_reg <= 4'h0;
      cmd_reg <= 8'h00;
      lo_reg <= 8'h00;
      hi_reg <= 8'h00;
      rd_reg <= 1'b0;
      tx_reg <= 8'h00;
      tx_idx_reg <= 2'h0;
      mack_reg <= 1'b0;
      sda_low_reg <= 1'b0;
    end else if (ce) begin
      state_reg <= state_next;
      bit_cnt_reg <= bit_cnt_next;
      shift_reg <= shift_next;
      byte_idx_reg <= byte_idx_next;
      wr_len_reg <= wr_len_next;
      cmd_reg <= cmd_next;
      lo_reg <= lo_next;
      hi_reg <= hi_next;
      rd_reg <= rd_next;
      tx_reg <= tx_next;
      tx_idx_reg <= tx_idx_next;
      mack_reg <= mack_next;
      sda_low_reg <= sda_low_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Mask bank and alert gating

  logic [alert_mask_pkg::NUM_MASKS-1:0][7:0] mask_reg;
  logic [alert_mask_pkg::NUM_MASKS-1:0] unmasked;

  genvar i;
  generate
    for (i = 0; i < alert_mask_pkg::NUM_MASKS; i++) begin : g_mask
      always_ff @(posedge mclk) begin
        if (!rst_n) begin
          mask_reg[i] <= nvm_mask[i] & alert_mask_pkg::NVM_RESET_BITS[i];
        end else if (ce && commit && wr_dec[2:0] == 3'(i)) begin
          mask_reg[i] <= hi_reg & alert_mask_pkg::WRITABLE[i];
        end
      end
      // Unsupported bits read zero, the misc source reads as masked
      assign mask_value[i] = (mask_reg[i] & alert_mask_pkg::WRITABLE[i])
        | alert_mask_pkg::FIXED_ONES[i];
      // Status is only gated here, never cleared or held off
      assign unmasked[i] = |(status_bits[i] & ~mask_value[i]);
    end
  endgenerate

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      alert_reg <= 1'b0;
      nvm_save <= 1'b0;
      nvm_save_idx <= 3'h0;
      nvm_save_data <= 8'h00;
    end else if (ce) begin
      alert_reg <= |unmasked;
      nvm_save <= commit;
      if (commit) begin
        nvm_save_idx <= wr_dec[2:0];
        nvm_save_data <= hi_reg & alert_mask_pkg::WRITABLE[wr_dec[2:0]];
      end
    end
  end

  assign alert_active = alert_reg;
  assign link.alert_dev_out = 1'b0;
  assign link.alert_dev_oe = alert_reg;
  assign link.sda_dev_out = 1'b0;
  assign link.sda_dev_oe = sda_low_reg;

endmodule

//--- hw/alert_mask_host.sv
// Host end: issues mask write words and mask read process calls
module alert_mask_host #(
  parameter logic [6:0] DEV_ADDR = alert_mask_pkg::DEFAULT_DEV_ADDR,
  parameter int QTR_CYC = alert_mask_pkg::SCL_QUARTER_CYC
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic ce,
  alert_link_if.host link,
  input wire logic start_req,
  input wire logic start_read,
  input wire logic [7:0] req_sel,
  input wire logic [7:0] req_mask,
  output logic busy,
  output logic done,
  output logic nack_err,
  output logic [7:0] rd_mask,
  output logic alert_seen
);

  typedef enum logic [3:0] {
    OP_IDLE = 4'b0001,
    OP_START = 4'b0010,
    OP_BYTE = 4'b0100,
    OP_STOP = 4'b1000
  } op_t;

  op_t state_reg;
  op_t op_kind;
  logic [7:0] op_byte_at_next;
  logic op_rx;
  logic op_nack;
  logic [3:0] step_reg;
  logic [1:0] qtr_reg;
  logic [7:0] qcnt_reg;
  logic [3:0] bit_reg;
  logic [7:0] shift_reg;
  logic ack_seen_reg;
  logic rd_reg;
  logic [7:0] sel_reg;
  logic [7:0] val_reg;
  logic scl_low_reg;
  logic sda_low_reg;
  logic sda_s1_reg, sda_s2_reg;
  logic alert_s1_reg, alert_s2_reg;

  ////////////////////////////////////////////////////////////////////////////////
  // Transaction plan per step

  wire [3:0] stop_step = rd_reg ? 4'h9 : 4'h5;
  wire [3:0] next_step = (state_reg == OP_BYTE && !op_rx && !ack_seen_reg) ? stop_step
    : step_reg + 4'h1;

  // Only the two bytes of a read answer come from the device; the last one is refused
  assign op_rx = step_reg == 4'h7 || step_reg == 4'h8;
  assign op_nack = step_reg == 4'h8;

  // Kind of the op being entered, so the state always matches the step it starts
  always_comb begin
    op_kind = OP_BYTE;
    if (!rd_reg && next_step > 4'h5) begin
      op_kind = OP_IDLE;
    end else if (next_step > 4'h9) begin
      op_kind = OP_IDLE;
    end else if (next_step == 4'h5) begin
      op_kind = rd_reg ? OP_START : OP_STOP;
    end else if (next_step == 4'h9) begin
      op_kind = OP_STOP;
    end
  end

  wire tick = (qcnt_reg == 8'(QTR_CYC - 1));
  wire op_end = tick && qtr_reg == 2'h3 && (state_reg != OP_BYTE || bit_reg == 4'h8);

  ////////////////////////////////////////////////////////////////////////////////
  // Bit engine: quarter 0 clock low, 1 data set, 2 clock high, 3 data or sample

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      state_reg <= OP_IDLE;
      step_reg <= 4'h0;
      qtr_reg <= 2'h0;
      qcnt_reg <= 8'h00;
      bit_reg <= 4'h0;
      shift_reg <= 8'h00;
      ack_seen_reg <= 1'b0;
      rd_reg <= 1'b0;
      sel_reg <= 8'h00;
      val_reg <= 8'h00;
      scl_low_reg <= 1'b0;
      sda_low_reg <= 1'b0;
      done <= 1'b0;
      nack_err <= 1'b0;
      rd_mask <= 8'h00;
    end else if (ce) begin
      done <= 1'b0;
      if (state_reg == OP_IDLE) begin
        qcnt_reg <= 8'h00;
        qtr_reg <= 2'h0;
        if (start_req) begin
          state_reg <= OP_START;
          step_reg <= 4'h0;
          bit_reg <= 4'h0;
          rd_reg <= start_read;
          sel_reg <= req_sel;
          val_reg <= req_mask;
          nack_err <= 1'b0;
          scl_low_reg <= 1'b1;
        end
      end else if (!tick) begin
        qcnt_reg <= qcnt_reg + 8'h01;
      end else begin
        qcnt_reg <= 8'h00;
        qtr_reg <= qtr_reg + 2'h1;
        case (qtr_reg)
          2'h0: begin
            if (state_reg == OP_START) begin
              sda_low_reg <= 1'b0;
            end else if (state_reg == OP_STOP) begin
              sda_low_reg <= 1'b1;
            end else if (bit_reg == 4'h8) begin
              sda_low_reg <= op_rx & ~op_nack;
            end else begin
              sda_low_reg <= ~op_rx & ~shift_reg[7];
            end
          end
          2'h1: scl_low_reg <= 1'b0;
          2'h2: begin
            if (state_reg == OP_START) begin
              sda_low_reg <= 1'b1;
            end else if (state_reg == OP_STOP) begin
              sda_low_reg <= 1'b0;
            end else if (bit_reg == 4'h8) begin
              ack_seen_reg <= ~sda_s2_reg;
            end else begin
              shift_reg <= {shift_reg[6:0], sda_s2_reg};
            end
          end
          default: begin
            if (state_reg == OP_BYTE && bit_reg != 4'h8) begin
              bit_reg <= bit_reg + 4'h1;
              scl_low_reg <= 1'b1;
            end else begin
              if (state_reg == OP_BYTE && !op_rx && !ack_seen_reg) begin
                nack_err <= 1'b1;
              end
              if (state_reg == OP_BYTE && op_nack) begin
                rd_mask <= shift_reg;
              end
              step_reg <= next_step;
              state_reg <= op_kind;
              bit_reg <= 4'h0;
              scl_low_reg <= state_reg != OP_STOP;
              done <= state_reg == OP_STOP;
            end
          end
        endcase
        if (op_end && state_reg != OP_STOP) begin
          shift_reg <= op_byte_at_next;
        end
      end
    end
  end

  // Load the byte of the following step as the current op closes
  always_comb begin
    case (next_step)
      4'h1: op_byte_at_next = {DEV_ADDR, 1'b0};
      4'h2: op_byte_at_next = alert_mask_pkg::MASK_CMD;
      // Write word puts selector low, mask high; read sends a one-byte block
      4'h3: op_byte_at_next = rd_reg ? alert_mask_pkg::BLOCK_COUNT : sel_reg;
      4'h4: op_byte_at_next = rd_reg ? sel_reg : val_reg;
      4'h6: op_byte_at_next = {DEV_ADDR, 1'b1};
      default: op_byte_at_next = alert_mask_pkg::FILL_BYTE;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      sda_s1_reg <= 1'b1;
      sda_s2_reg <= 1'b1;
      alert_s1_reg <= 1'b1;
      alert_s2_reg <= 1'b1;
    end else if (ce) begin
      sda_s1_reg <= link.sda;
      sda_s2_reg <= sda_s1_reg;
      alert_s1_reg <= link.alert_n;
      alert_s2_reg <= alert_s1_reg;
    end
  end

  assign busy = state_reg != OP_IDLE;
  assign alert_seen = ~alert_s2_reg;
  assign link.scl_host_out = 1'b0;
  assign link.scl_host_oe = scl_low_reg;
  assign link.sda_host_out = 1'b0;
  assign link.sda_host_oe = sda_low_reg;

endmodule

//--- bench/alert_link_properties.sv
// Timing and ownership checks on the open-drain link between host and mask bank
module alert_link_properties (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic scl,
  input wire logic sda,
  input wire logic scl_host_out,
  input wire logic scl_host_oe,
  input wire logic sda_host_out,
  input wire logic sda_host_oe,
  input wire logic sda_dev_out,
  input wire logic sda_dev_oe,
  input wire logic alert_dev_out
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  ////////////////////////////////////////////////////////////////////////////////
  sequence s_start;
    scl && $fell(sda);
  endsequence
  sequence s_stop;
    scl && $rose(sda);
  endsequence
  property p_open_drain;
    !scl_host_out && !sda_host_out && !sda_dev_out && !alert_dev_out;
  endproperty
  property p_start_by_host;
    s_start |-> sda_host_oe;
  endproperty
  property p_start_clocks;
    s_start |-> ##[1:8] !scl;
  endproperty
  // The device must stay off the data line for four cycles after a stop
  property p_stop_quiet;
    s_stop |=> !sda_dev_oe [*4];
  endproperty
  property p_scl_low;
    $fell(scl) |-> !scl [*5];
  endproperty
  property p_scl_high;
    $rose(scl) |-> scl [*5];
  endproperty
  property p_dev_scl_low;
    $changed(sda_dev_oe) |-> !scl;
  endproperty
  property p_dev_hold;
    $rose(sda_dev_oe) |-> sda_dev_oe [*8];
  endproperty
  property p_dev_release;
    $rose(sda_dev_oe) |-> ##[1:120] !sda_dev_oe;
  endproperty
  ////////////////////////////////////////////////////////////////////////////////
  a_open_drain: assert property (p_open_drain)
    else $error("open-drain output driven high");
  a_start_by_host: assert property (p_start_by_host)
    else $error("start condition not made by host");
  a_start_clocks: assert property (p_start_clocks)
    else $error("no clock after start");
  a_stop_quiet: assert property (p_stop_quiet)
    else $error("device drives data after stop");
  a_scl_low: assert property (p_scl_low)
    else $error("clock low phase too short");
  a_scl_high: assert property (p_scl_high)
    else $error("clock high phase too short");
  a_dev_scl_low: assert property (p_dev_scl_low)
    else $error("device changed data while clock high");
  a_dev_hold: assert property (p_dev_hold)
    else $error("device data bit too short");
  a_dev_release: assert property (p_dev_release)
    else $error("device holds data line too long");
endmodule

//--- bench/tb_top.sv
// Random and corner traffic between host and mask bank, with reference checks
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int N = alert_mask_pkg::NUM_MASKS;
  localparam logic [7:0] SELS [6] = '{8'h7c, 8'h7d, 8'h7e, 8'h7f, 8'h80, 8'h7b};
  localparam logic [7:0] WR_BITS [N] = '{8'he8, 8'hc0, 8'hfa, 8'h00, 8'h00};
  localparam logic [7:0] NV_BITS [N] = '{8'h08, 8'hc0, 8'hfa, 8'h00, 8'h00};
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic start_req = 1'b0;
  logic start_read = 1'b0;
  logic [7:0] req_sel = 8'h00;
  logic [7:0] req_mask = 8'h00;
  logic [7:0] phase_value = 8'hff;
  logic [N-1:0][7:0] nvm_mask = '0;
  logic [N-1:0][7:0] status_bits = '0;
  logic nvm_save, busy, done, nack_err, alert_active, alert_seen;
  logic [2:0] nvm_save_idx, last_idx;
  logic [7:0] nvm_save_data, rd_mask, last_dat;
  logic [N-1:0][7:0] mask_value;
  logic [7:0] exp_mask [N];
  int n_mismatch = 0;
  int check_count = 0;
  int save_n = 0;
  int seed = 32'h8a148639;
  alert_link_if link ();
  alert_source_mask_bank u_alert_source_mask_bank (.mclk(mclk), .rst_n(rst_n), .ce(1'b1),
    .link(link.device), .phase_value(phase_value), .nvm_mask(nvm_mask),
    .status_bits(status_bits), .nvm_save(nvm_save), .nvm_save_idx(nvm_save_idx),
    .nvm_save_data(nvm_save_data), .mask_value(mask_value), .alert_active(alert_active));
  alert_mask_host u_alert_mask_host (.mclk(mclk), .rst_n(rst_n), .ce(1'b1),
    .link(link.host), .start_req(start_req), .start_read(start_read), .req_sel(req_sel),
    .req_mask(req_mask), .busy(busy), .done(done), .nack_err(nack_err), .rd_mask(rd_mask),
    .alert_seen(alert_seen));
  alert_link_properties u_alert_link_properties (.mclk(mclk), .rst_n(rst_n),
    .scl(link.scl), .sda(link.sda), .scl_host_out(link.scl_host_out),
    .scl_host_oe(link.scl_host_oe), .sda_host_out(link.sda_host_out),
    .sda_host_oe(link.sda_host_oe), .sda_dev_out(link.sda_dev_out),
    .sda_dev_oe(link.sda_dev_oe), .alert_dev_out(link.alert_dev_out));
  initial forever #25 mclk = ~mclk;
  ////////////////////////////////////////////////////////////////////////////////
  always @(posedge mclk) begin
    if (nvm_save === 1'b1) begin
      save_n <= save_n + 1;
      last_idx <= nvm_save_idx;
      last_dat <= nvm_save_data;
    end
  end
  task automatic chk(input string what, input logic [7:0] e, input logic [7:0] g);
    check_count++;
    if (g !== e) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic conclude();
    if (n_mismatch == 0 && check_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  function automatic logic [7:0] ref_alert();
    logic a;
    a = 1'b0;
    for (int i = 0; i < N; i++) a |= |(status_bits[i] & ~exp_mask[i]);
    return {7'h00, a};
  endfunction
  // Commit lands a few cycles after the stop, so settle before looking
  task automatic xfer(input logic rd, input logic [7:0] sel, input logic [7:0] msk);
    int k;
    @(negedge mclk);
    start_req = 1'b1;
    start_read = rd;
    req_sel = sel;
    req_mask = msk;
    @(negedge mclk);
    start_req = 1'b0;
    chk("busy", 8'h01, {7'h00, busy});
    k = 0;
    while (done !== 1'b1 && k < 3000) begin
      @(negedge mclk);
      k++;
    end
    if (k >= 3000) begin
      n_mismatch++;
      conclude();
    end
    repeat (6) @(negedge mclk);
    chk("nack_err", 8'h00, {7'h00, nack_err});
    chk("busy", 8'h00, {7'h00, busy});
  endtask
  task automatic rdchk(input int i);
    xfer(1'b1, SELS[i], 8'h00);
    chk("rd_mask", (i < N) ? exp_mask[i] : 8'h00, rd_mask);
  endtask
  task automatic do_reset();
    rst_n = 1'b0;
    nvm_mask = {8'($random(seed)), 32'($random(seed))};
    repeat (20) @(negedge mclk);
    rst_n = 1'b1;
    for (int i = 0; i < N; i++) begin
      exp_mask[i] = (nvm_mask[i] & NV_BITS[i]) | ((i == 3) ? 8'h01 : 8'h00);
      chk("reset_mask", exp_mask[i], mask_value[i]);
    end
    chk("reset_rd", 8'h00, rd_mask);
    chk("reset_oe", 8'h00, {4'h0, link.scl_host_oe, link.sda_host_oe, link.sda_dev_oe,
      link.alert_dev_oe});
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    int idx;
    int sv;
    logic [7:0] msk;
    do_reset();
    for (int i = 0; i < 6; i++) rdchk(i);
    for (int r = 0; r < 24; r++) begin
      idx = (r < 12) ? r % 6 : {$random(seed)} % 6;
      msk = (r < 6) ? 8'hff : (r < 12) ? 8'h00 : 8'($random(seed));
      phase_value = (r % 5 == 4) ? (8'($random(seed)) & 8'hfe) : 8'hff;
      sv = save_n;
      xfer(1'b0, SELS[idx], msk);
      if (idx < N && phase_value === 8'hff) begin
        exp_mask[idx] = (exp_mask[idx] & ~WR_BITS[idx]) | (msk & WR_BITS[idx]);
      end
      if (idx < 3 && phase_value === 8'hff) begin
        chk("save_count", 8'(sv + 1), 8'(save_n));
        chk("save_data", exp_mask[idx], last_dat);
        chk("save_idx", 8'(idx), {5'h00, last_idx});
      end else if (idx == 5 || phase_value !== 8'hff) begin
        chk("save_count", 8'(sv), 8'(save_n));
      end
      for (int i = 0; i < N; i++) chk("mask_value", exp_mask[i], mask_value[i]);
      rdchk(idx);
      // Corners: misc source alone, then every set bit masked
      if (r == 0) status_bits = 40'h0001000000;
      else if (r == 1) status_bits = {exp_mask[4], exp_mask[3], exp_mask[2], exp_mask[1],
        exp_mask[0]};
      else status_bits = {8'($random(seed)), 32'($random(seed))};
      repeat (4) @(negedge mclk);
      chk("alert_active", ref_alert(), {7'h00, alert_active});
      chk("alert_seen", ref_alert(), {7'h00, alert_seen});
    end
    do_reset();
    conclude();
  end
endmodule
